// file: src/tds_tap.sv
// tap detection core: thresholds, time limit, latched source register
// assumes synchronous inputs, one sample strobe per output sample, host register port
`timescale 1ns/1ps
`default_nettype none

// Function
// - a tap sets flags only when its axis and tap kind are enabled
// - bit 7 reads one once any enabled tap event has been reported
// - bits 6..4 report taps seen on z, y and x
// - bit 3 reads one for a double tap, zero for a single tap
// - bits 2..0 give negative polarity of the z, y and x tap
// - with latching on, a set event freezes all status bits until cleared
// - reading the source register clears all of its bits
// - reading the source register also drops the tap interrupt request
// - each axis threshold is seven bits, bit 7 reads zero, resets to zero
// - thresholds compare at fixed 8 g scale, 0.063 g per count
// - detection starts when an axis exceeds its threshold
// - time limit bounds the time above threshold for a valid tap
// - limit counts in time steps, longest interval 255 steps
// - with lowpass on the step follows rate and mode, from 1.25 ms
// - with lowpass off the step follows rate and mode, from 0.625 ms, fixed at 0.625 ms in high res mode
// - with latching off flags follow each new event
// - separate single and double enables per axis, all off at reset
module tds_tap
   import tds_pkg::*;
#(
   parameter int BASE_CYCLES = tds_pkg::BASE_STEP_CYCLES
) (
   input  wire logic               CLK,
   input  wire logic               RST_N,
   input  wire tds_pkg::tds_sample_s SAMPLE,
   input  wire tds_pkg::tds_cfg_s  CFG,
   input  wire tds_pkg::tds_regreq_s REG_REQ,
   output logic [7:0]              REG_RDATA,
   output logic                    TAP_IRQ
);
   import tds_pkg::*;

   // ======================================================
   // state
   typedef struct packed {
      tds_axis_s [2:0]              axis;
      tds_source_s                  src;
      logic [2:0][THR_W-1:0]        thr;
      logic [LIMIT_W-1:0]           tlim;
      logic [BASE_CNT_W-1:0]        base_cnt;
      logic [STEP_CNT_W-1:0]        step_cnt;
      logic [7:0]                   rdata;
   } tds_state_s;

   tds_state_s                      st;
   tds_state_s                      next_st;
   logic                            base_tick;
   logic                            step_tick;
   logic [3:0]                      step_log2;
   logic [STEP_CNT_W-1:0]           step_last;
   logic [2:0]                      tap_axis;
   logic [2:0]                      tap_ok;
   logic                            ev_any;
   logic                            src_read;
   logic [2:0][ACC_W-1:0]           acc_mag;
   logic [2:0][7:0]                 acc_scaled;
   logic [2:0]                      over;
   logic [3:0]                      scale_sh;

   // ======================================================
   // time step generation
   always_comb begin
      step_log2 = 4'(STEP_LOG2_TABLE[{CFG.tap_lowpass_enable, CFG.mode}]
                     >> {CFG.output_sample_rate, 2'b00});
      step_last = STEP_CNT_W'((STEP_CNT_W'(1) << step_log2) - STEP_CNT_W'(1));
      base_tick = (st.base_cnt == BASE_CNT_W'(BASE_CYCLES - 1));
      // at or past the last count, so a shorter step taken mid-count cannot stall the divider
      step_tick = base_tick && (st.step_cnt >= step_last);
   end

   // ======================================================
   // acceleration scaled to the fixed 8 g threshold grid
   always_comb begin
      scale_sh = 4'(SCALE_BASE_SH) + 4'(FS_8G - CFG.full_scale);
      for (int i = 0; i < 3; i++) begin
         acc_mag[i] = 12'h000;
         acc_scaled[i] = 8'h00;
         over[i] = 1'b0;
      end
      acc_mag[0] = SAMPLE.x[ACC_W-1] ? ACC_W'(-SAMPLE.x) : ACC_W'(SAMPLE.x);
      acc_mag[1] = SAMPLE.y[ACC_W-1] ? ACC_W'(-SAMPLE.y) : ACC_W'(SAMPLE.y);
      acc_mag[2] = SAMPLE.z[ACC_W-1] ? ACC_W'(-SAMPLE.z) : ACC_W'(SAMPLE.z);
      for (int i = 0; i < 3; i++) begin
         acc_scaled[i] = 8'(acc_mag[i] >> scale_sh);
         over[i] = acc_scaled[i] > {1'b0, st.thr[i]};
      end
   end

   // ======================================================
   // next state
   always_comb begin
      next_st = st;
      tap_axis = 3'h0;
      tap_ok = 3'h0;
      src_read = REG_REQ.rd && (REG_REQ.addr == ADDR_TAP_SOURCE_STATUS);

      // step divider
      next_st.base_cnt = base_tick ? '0 : BASE_CNT_W'(st.base_cnt + 1'b1);
      if (base_tick) begin
         next_st.step_cnt = step_tick ? '0 : STEP_CNT_W'(st.step_cnt + 1'b1);
      end

      // per axis excursion tracking
      for (int i = 0; i < 3; i++) begin
         if (st.axis[i].above && step_tick && !st.axis[i].expired) begin
            if (st.axis[i].time_limit_count >= st.tlim) begin
               next_st.axis[i].expired = 1'b1;
            end else begin
               next_st.axis[i].time_limit_count =
                  LIMIT_W'(st.axis[i].time_limit_count + 1'b1);
            end
         end
         if (SAMPLE.valid) begin
            if (!st.axis[i].above && over[i]) begin
               next_st.axis[i].above = 1'b1;
               next_st.axis[i].expired = 1'b0;
               next_st.axis[i].time_limit_count = '0;
               next_st.axis[i].sign = (i == 0) ? SAMPLE.x[ACC_W-1] :
                                      (i == 1) ? SAMPLE.y[ACC_W-1] : SAMPLE.z[ACC_W-1];
            end else if (st.axis[i].above && !over[i]) begin
               next_st.axis[i].above = 1'b0;
               tap_axis[i] = !st.axis[i].expired;
            end
         end
         tap_ok[i] = tap_axis[i] && (SAMPLE.second_tap ? CFG.double_enable[i]
                                                      : CFG.single_enable[i]);
      end
      ev_any = |tap_ok;

      // source register, clear on read, new event wins
      if (src_read) begin
         next_st.src = SOURCE_RESET;
      end
      if (ev_any && !(CFG.flag_latch_enable && st.src.event_active_flag && !src_read)) begin
         next_st.src.event_active_flag = 1'b1;
         next_st.src.z_axis_event = tap_ok[2];
         next_st.src.y_axis_event = tap_ok[1];
         next_st.src.x_axis_event = tap_ok[0];
         next_st.src.double_tap_flag = SAMPLE.second_tap;
         next_st.src.z_negative_sign = tap_ok[2] && st.axis[2].sign;
         next_st.src.y_negative_sign = tap_ok[1] && st.axis[1].sign;
         next_st.src.x_negative_sign = tap_ok[0] && st.axis[0].sign;
      end

      // host writes
      if (REG_REQ.wr) begin
         case (REG_REQ.addr)
            ADDR_TAP_THRESHOLD_X: begin
               next_st.thr[0] = REG_REQ.wdata[THR_W-1:0];
            end
            ADDR_TAP_THRESHOLD_Y: begin
               next_st.thr[1] = REG_REQ.wdata[THR_W-1:0];
            end
            ADDR_TAP_THRESHOLD_Z: begin
               next_st.thr[2] = REG_REQ.wdata[THR_W-1:0];
            end
            ADDR_TAP_TIME_LIMIT: begin
               next_st.tlim = REG_REQ.wdata;
            end
            default: begin
               next_st.tlim = st.tlim;
            end
         endcase
      end

      // host reads, data one cycle later
      if (REG_REQ.rd) begin
         case (REG_REQ.addr)
            ADDR_TAP_SOURCE_STATUS: begin
               next_st.rdata = st.src;
            end
            ADDR_TAP_THRESHOLD_X: begin
               next_st.rdata = {1'b0, st.thr[0]};
            end
            ADDR_TAP_THRESHOLD_Y: begin
               next_st.rdata = {1'b0, st.thr[1]};
            end
            ADDR_TAP_THRESHOLD_Z: begin
               next_st.rdata = {1'b0, st.thr[2]};
            end
            ADDR_TAP_TIME_LIMIT: begin
               next_st.rdata = st.tlim;
            end
            default: begin
               next_st.rdata = RDATA_UNMAPPED;
            end
         endcase
      end
   end

   // ======================================================
   // registers
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign REG_RDATA = st.rdata;
   assign TAP_IRQ = st.src.event_active_flag;

   // ======================================================
   // assertions
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   AST_READ_CLEARS: assert property (src_read && !ev_any |=> st.src == SOURCE_RESET)
      else $error("source register not cleared by read");
   AST_READ_DROPS_IRQ: assert property (src_read && !ev_any |=> !TAP_IRQ)
      else $error("tap interrupt stays after source read");
   AST_FROZEN: assert property (CFG.flag_latch_enable && st.src.event_active_flag && !src_read
                                |=> $stable(st.src))
      else $error("latched source register changed");
   AST_THR_BIT7: assert property (REG_REQ.rd && REG_REQ.addr == ADDR_TAP_THRESHOLD_X
                                  |=> REG_RDATA[7] == 1'b0 && REG_RDATA[6:0] == $past(st.thr[0]))
      else $error("threshold readback wrong");
   AST_EA_CAUSE: assert property ($rose(st.src.event_active_flag) |-> $past(ev_any))
      else $error("event flag set without enabled tap");
   AST_EA_AXIS: assert property (st.src.event_active_flag |->
                                 (st.src.x_axis_event || st.src.y_axis_event || st.src.z_axis_event))
      else $error("event flag without axis");
   AST_EA_ONLY_EVENT: assert property (!st.src.event_active_flag |->
                                       st.src[6:0] == 7'h00)
      else $error("status bits set without event flag");
   AST_POL_AXIS: assert property (st.src.x_negative_sign |-> st.src.x_axis_event)
      else $error("polarity without axis event");
   AST_DOUBLE_TAG: assert property (ev_any && !st.src.event_active_flag && !src_read
                                    |=> st.src.double_tap_flag == $past(SAMPLE.second_tap))
      else $error("double tap flag wrong");
   AST_LIMIT: assert property (st.axis[0].above && !st.axis[0].expired && step_tick
                               && st.axis[0].time_limit_count >= st.tlim
                               |=> st.axis[0].expired)
      else $error("excursion not discarded at limit");
   AST_STEP_ON_BASE: assert property (step_tick |-> base_tick)
      else $error("step without base tick");

   COV_SINGLE: cover property (ev_any && !SAMPLE.second_tap);
   COV_DOUBLE: cover property (ev_any && SAMPLE.second_tap);
   COV_FREEZE: cover property (CFG.flag_latch_enable && st.src.event_active_flag && ev_any);
   COV_EXPIRE: cover property ($rose(st.axis[0].expired));

endmodule

`default_nettype wire

// file: include/tds_pkg.sv
// tap detection package: register map, field layout, step table, carrier types
// assumes a 40 MHz single clock and a synchronous register port
package tds_pkg;

   // ======================================================
   // register map
   localparam logic [7:0] ADDR_TAP_SOURCE_STATUS = 8'h22;
   localparam logic [7:0] ADDR_TAP_THRESHOLD_X   = 8'h23;
   localparam logic [7:0] ADDR_TAP_THRESHOLD_Y   = 8'h24;
   localparam logic [7:0] ADDR_TAP_THRESHOLD_Z   = 8'h25;
   localparam logic [7:0] ADDR_TAP_TIME_LIMIT    = 8'h26;

   // ======================================================
   // field layout and reset values
   localparam int         THR_W          = 7;
   localparam int         LIMIT_W        = 8;
   localparam int         ACC_W          = 12;
   localparam int         SCALE_BASE_SH  = 4;
   localparam logic [1:0] FS_8G          = 2'h2;
   localparam logic [7:0] SOURCE_RESET   = 8'h00;
   localparam logic [6:0] THR_RESET      = 7'h00;
   localparam logic [7:0] LIMIT_RESET    = 8'h00;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

   // ======================================================
   // timing
   localparam int CLK_PERIOD_NS     = 25;
   localparam int BASE_STEP_NS      = 625000;
   localparam int BASE_STEP_CYCLES  = (BASE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BASE_CNT_W        = 24;
   localparam int STEP_CNT_W        = 9;

   // step length as log2 of base steps, one nibble per rate code,
   // entry index is {lowpass, mode}
   localparam logic [7:0][31:0] STEP_LOG2_TABLE = {
      32'h88754321, 32'h22222221, 32'h77754321, 32'h55554321,
      32'h66643210, 32'h00000000, 32'h55532100, 32'h33332100};

   // ======================================================
   // types
   typedef enum logic [1:0] {
      TDS_MODE_NORMAL    = 2'h0,
      TDS_MODE_LOW_NOISE = 2'h1,
      TDS_MODE_HIGH_RES  = 2'h2,
      TDS_MODE_LOW_POWER = 2'h3
   } tds_mode_e;

   typedef struct packed {
      logic                    event_active_flag;
      logic                    z_axis_event;
      logic                    y_axis_event;
      logic                    x_axis_event;
      logic                    double_tap_flag;
      logic                    z_negative_sign;
      logic                    y_negative_sign;
      logic                    x_negative_sign;
   } tds_source_s;

   typedef struct packed {
      logic                    above;
      logic                    expired;
      logic                    sign;
      logic [LIMIT_W-1:0]      time_limit_count;
   } tds_axis_s;

   typedef struct packed {
      logic                    valid;
      logic                    second_tap;
      logic signed [ACC_W-1:0] z;
      logic signed [ACC_W-1:0] y;
      logic signed [ACC_W-1:0] x;
   } tds_sample_s;

   typedef struct packed {
      logic                    flag_latch_enable;
      logic [2:0]              double_enable;
      logic [2:0]              single_enable;
      logic                    tap_lowpass_enable;
      logic [2:0]              output_sample_rate;
      tds_mode_e               mode;
      logic [1:0]              full_scale;
   } tds_cfg_s;

   typedef struct packed {
      logic                    rd;
      logic                    wr;
      logic [7:0]              addr;
      logic [7:0]              wdata;
   } tds_regreq_s;

endpackage

// file: bench/tds_host_model.sv
// host model: register port master and configuration owner
// assumes the bench calls its tasks and runs the clock
`timescale 1ns/1ps
`default_nettype none
module tds_host_model
   import tds_pkg::*;
(
   input  wire logic                CLK,
   input  wire logic [7:0]          RDATA,
   output var  tds_pkg::tds_regreq_s REQ,
   output var  tds_pkg::tds_cfg_s    CFG
);
   initial begin
      REQ = '0;
      CFG = '0;
   end

   // ==================================================
   // configuration, lowpass chosen by the host
   task automatic set_cfg(input tds_cfg_s c);
      @(negedge CLK);
      CFG = c;
   endtask

   // ==================================================
   // register access, one request per cycle
   task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
      @(negedge CLK);
      REQ = '{1'b0, 1'b1, addr, data};
      @(negedge CLK);
      REQ = '0;
   endtask

   task automatic reg_rd(input logic [7:0] addr, output logic [7:0] data);
      @(negedge CLK);
      REQ = '{1'b1, 1'b0, addr, 8'h00};
      @(negedge CLK);
      REQ = '0;
      data = RDATA;
   endtask
endmodule
`default_nettype wire

// file: bench/tds_tap_tb_top.sv
// testbench top: register and tap scenarios for the tap core
// assumes the host model owns the register port and configuration
`timescale 1ns/1ps
`default_nettype none
module tds_tap_tb_top;
   import tds_pkg::*;
   localparam int BASE = 4;
   localparam logic [7:0] SRC = ADDR_TAP_SOURCE_STATUS;
   logic        clk;
   logic        rst_n;
   tds_sample_s sample;
   tds_cfg_s    cfg;
   tds_regreq_s req;
   logic [7:0]  rdata;
   logic        irq;
   logic [7:0]  val;
   int          n_fail;
   int          comparisons;
   int          cycles;
   // lowpass, rate, mode, tap expected
   logic [7:0]  stp [6] = '{8'h00, 8'h81, 8'h1D, 8'h10, 8'h78, 8'hF9};

   tds_tap #(.BASE_CYCLES(BASE)) tds_tap_i (
      .CLK       (clk),
      .RST_N     (rst_n),
      .SAMPLE    (sample),
      .CFG       (cfg),
      .REG_REQ   (req),
      .REG_RDATA (rdata),
      .TAP_IRQ   (irq)
   );

   tds_host_model tds_host_model_i (
      .CLK   (clk),
      .RDATA (rdata),
      .REQ   (req),
      .CFG   (cfg)
   );

   // ==================================================
   // clock and timeout
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         finish_test();
      end
   end

   // ==================================================
   // helpers
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         n_fail++;
      end
   endtask

   task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
      tds_host_model_i.reg_rd(addr, val);
      chk($sformatf("reg %h", addr), exp, val);
   endtask

   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      tds_host_model_i.reg_wr(addr, data);
   endtask

   task automatic smp(input logic signed [11:0] x, y, z, input logic dbl);
      @(negedge clk);
      sample = '{1'b1, dbl, z, y, x};
      @(negedge clk);
      sample.valid = 1'b0;
   endtask

   task automatic tap(input logic signed [11:0] x, y, z, input logic dbl, input int gap);
      smp(x, y, z, dbl);
      repeat (gap) @(negedge clk);
      smp(12'sh000, 12'sh000, 12'sh000, dbl);
   endtask

   task automatic cfg_set(input logic le, input logic [2:0] de, se, input logic [7:0] s);
      tds_host_model_i.set_cfg('{le, de, se, s[7], s[6:4], tds_mode_e'(s[3:2]), FS_8G});
   endtask

   task automatic finish_test();
      $display("counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ==================================================
   // main sequence
   initial begin
      sample = '0;
      rst_n = 1'b0;
      repeat (8) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      for (int a = 8'h22; a <= 8'h26; a++) rd(a[7:0], 8'h00);
      rd(8'h30, RDATA_UNMAPPED);
      for (int a = 8'h23; a <= 8'h25; a++) begin
         wr(a[7:0], 8'hFF);
         rd(a[7:0], 8'h7F);
         wr(a[7:0], 8'h0A);
      end
      wr(ADDR_TAP_TIME_LIMIT, 8'hA5);
      rd(ADDR_TAP_TIME_LIMIT, 8'hA5);
      wr(SRC, 8'hFF);
      rd(SRC, 8'h00);
      wr(ADDR_TAP_TIME_LIMIT, 8'hFF);
      $display("test registers done");

      cfg_set(1'b1, 3'h0, 3'h1, 8'h00);
      tap(12'sh0A0, 12'sh000, 12'sh000, 1'b0, 3);
      rd(SRC, 8'h00);
      tap(12'sh0B0, 12'sh000, 12'sh000, 1'b0, 3);
      chk("irq", 8'h01, {7'h00, irq});
      rd(SRC, 8'h90);
      chk("irq", 8'h00, {7'h00, irq});
      rd(SRC, 8'h00);
      tap(12'sh000, 12'sh0B0, 12'sh000, 1'b0, 3);
      tap(12'sh0B0, 12'sh000, 12'sh000, 1'b1, 3);
      rd(SRC, 8'h00);
      $display("test single tap done");

      cfg_set(1'b1, 3'h4, 3'h1, 8'h00);
      tap(12'sh000, 12'sh000, -12'sh0B0, 1'b1, 3);
      tap(12'sh0B0, 12'sh000, 12'sh000, 1'b0, 3);
      rd(SRC, 8'hCC);
      cfg_set(1'b0, 3'h4, 3'h1, 8'h00);
      tap(12'sh000, 12'sh000, -12'sh0B0, 1'b1, 3);
      tap(12'sh0B0, 12'sh000, 12'sh000, 1'b0, 3);
      rd(SRC, 8'h90);
      $display("test latch done");

      wr(ADDR_TAP_TIME_LIMIT, 8'h04);
      for (int i = 0; i < 6; i++) begin
         cfg_set(1'b1, 3'h0, 3'h1, stp[i]);
         tap(12'sh0B0, 12'sh000, 12'sh000, 1'b0, 24);
         rd(SRC, stp[i][0] ? 8'h90 : 8'h00);
      end
      $display("test time limit done");
      finish_test();
   end
endmodule
`default_nettype wire
